// *** design/slpx_regs.svh ***
// Register offsets, field positions and reset values for spare-lane power control
`ifndef SLPX_REGS_SVH
`define SLPX_REGS_SVH

`define SLPX_OFF_LINK_EN 10'h200
`define SLPX_OFF_STATUS 10'h201
`define SLPX_OFF_PWR_DOWN 10'h209
`define SLPX_OFF_SPARE_A 10'h20A
`define SLPX_OFF_SPARE_B 10'h20B
`define SLPX_OFF_SYNC_MODE 10'h20F

`define SLPX_RST_BYTE 8'h00
`define SLPX_PD_A_BIT 0
`define SLPX_PD_B_BIT 1
`define SLPX_SPARE_SER_BIT 0
`define SLPX_LINK_EN_BIT 0
`define SLPX_SHM_LO 0
`define SLPX_SHM_HI 1

`define SLPX_TP_NORMAL 3'h0
`define SLPX_TP_ALT 3'h5
`define SLPX_SHM_CRC 2'h0
`define SLPX_SHM_FEC 2'h2
`define SLPX_CAL_OFF_ONE 2'h1
`define SLPX_CAL_OFF_NONE 2'h0

`define SLPX_AV_CTRL 3'h0
`define SLPX_AV_PD 3'h1
`define SLPX_AV_SPARE_A 3'h2
`define SLPX_AV_SPARE_B 3'h3
`define SLPX_AV_SYNC_MODE 3'h4
`define SLPX_AV_STATUS 3'h5
`define SLPX_CTRL_GO_BIT 0
`define SLPX_CTRL_LINK_BIT 1
`define SLPX_ST_BUSY_BIT 0
`define SLPX_ST_REFUSED_BIT 1

`endif

// *** design/slpx_pkg.sv ***
// Shared types for spare-lane power control
package slpx_pkg;
	typedef logic [7:0] slpx_byte_t;
	typedef logic [9:0] slpx_addr_t;
	typedef logic [7:0] slpx_lanes_t;
	typedef enum logic [3:0] {
		SLPX_IDLE, SLPX_DIS, SLPX_PD, SLPX_XA, SLPX_XB, SLPX_SH, SLPX_EN, SLPX_STAT
	} slpx_state_t;
endpackage

// *** design/slpx_if.sv ***
// Register port between the controller and the device
`timescale 1ns/1ps
interface slpx_if;
	logic req;
	logic we;
	slpx_pkg::slpx_addr_t addr;
	slpx_pkg::slpx_byte_t wdata;
	slpx_pkg::slpx_byte_t rdata;
	logic ack;
	modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
	modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface

// *** design/slpx_lane_gate.sv ***
// Per-link lane clock, serializer and ramp gating
`timescale 1ns/1ps
module slpx_lane_gate (
	input wire logic link_on_i,
	input wire slpx_pkg::slpx_lanes_t mode_lanes_i,
	input wire slpx_pkg::slpx_byte_t spare_i,
	input wire logic [2:0] test_sel_i,
	output slpx_pkg::slpx_lanes_t clk_en_o,
	output slpx_pkg::slpx_lanes_t ser_en_o,
	output slpx_pkg::slpx_lanes_t ramp_o
);
	import slpx_pkg::*;
	`include "slpx_regs.svh"

	slpx_lanes_t lane_on;
	slpx_lanes_t spare_only;
	slpx_lanes_t ser_want;
	slpx_lanes_t lower_ok;
	logic ramp_case;
	logic spare_ser;

	assign spare_ser = spare_i[`SLPX_SPARE_SER_BIT];
	assign ramp_case = (test_sel_i == `SLPX_TP_NORMAL) || (test_sel_i == `SLPX_TP_ALT);
	assign lower_ok[0] = 1'b1;

	genvar n;
	generate
		for (n = 0; n < 8; n++) begin : g_lane
			if (n == 0) begin : g_first
				assign spare_only[n] = 1'b0;
			end else begin : g_rest
				assign spare_only[n] = spare_i[n] & ~mode_lanes_i[n];
				assign lower_ok[n] = lower_ok[n-1] & lane_on[n-1];
			end
			// Spare bits cannot wake a link whose channel is off
			assign lane_on[n] = link_on_i & (mode_lanes_i[n] | spare_only[n]);
			assign ser_want[n] = mode_lanes_i[n] | (spare_only[n] & spare_ser);
			assign clk_en_o[n] = lane_on[n];
			assign ser_en_o[n] = lane_on[n] & ser_want[n] & lower_ok[n];
			assign ramp_o[n] = lane_on[n] & spare_only[n] & ramp_case;
		end
	endgenerate
endmodule

// *** design/slpx_device.sv ***
// Device end: power-down, spare-lane and sync-header registers and gating
//
// Our own choice: the req/ack register port (slpx_if) to the registers.
`timescale 1ns/1ps
module slpx_device (
	input wire logic MCLK_I,
	input wire logic RST_B_I,
	slpx_if.dev REG,
	input wire slpx_pkg::slpx_lanes_t MODE_LANES_A_I,
	input wire slpx_pkg::slpx_lanes_t MODE_LANES_B_I,
	input wire logic MODE_BOTH_ON_A_I,
	input wire logic MODE_64B66B_I,
	input wire logic [2:0] TEST_SEL_I,
	input wire logic [3:0] DIG_CHAN_BIND_I,
	output logic CHAN_A_ON_O,
	output logic CHAN_B_ON_O,
	output logic [3:0] DIG_CHAN_ON_O,
	output logic SUBSYS_ON_O,
	output logic LINK_ENABLE_O,
	output slpx_pkg::slpx_lanes_t LANE_CLK_A_O,
	output slpx_pkg::slpx_lanes_t LANE_SER_A_O,
	output slpx_pkg::slpx_lanes_t LANE_RAMP_A_O,
	output slpx_pkg::slpx_lanes_t LANE_CLK_B_O,
	output slpx_pkg::slpx_lanes_t LANE_SER_B_O,
	output slpx_pkg::slpx_lanes_t LANE_RAMP_B_O,
	output logic SLOT_B_UNDEF_O,
	output logic SYNC_CRC_O,
	output logic SYNC_FEC_O
);
	import slpx_pkg::*;
	`include "slpx_regs.svh"

	// Register group
	logic link_enable;
	slpx_byte_t converter_channel_power_down;
	slpx_byte_t spare_lane_enable_link_a;
	slpx_byte_t spare_lane_enable_link_b;
	slpx_byte_t sync_header_mode_select;
	logic ack;
	slpx_byte_t rdata;
	logic next_link_enable;
	slpx_byte_t next_pd;
	slpx_byte_t next_spare_a;
	slpx_byte_t next_spare_b;
	slpx_byte_t next_sync_header_mode;
	logic next_ack;
	slpx_byte_t next_rdata;
	logic take;

	// Derived power state
	logic chan_a_power_down;
	logic chan_b_power_down;
	logic chan_a_on;
	logic chan_b_on;
	logic subsys_on;
	logic link_a_on;
	logic link_b_on;
	logic [3:0] dig_on;
	slpx_byte_t status;
	slpx_lanes_t clk_a;
	slpx_lanes_t ser_a;
	slpx_lanes_t ramp_a;
	slpx_lanes_t clk_b;
	slpx_lanes_t ser_b;
	slpx_lanes_t ramp_b;
	logic [1:0] shm;

	// Output group
	logic next_chan_a_on;
	logic next_chan_b_on;
	logic [3:0] next_dig_on;
	logic next_subsys_on;
	slpx_lanes_t next_clk_a;
	slpx_lanes_t next_ser_a;
	slpx_lanes_t next_ramp_a;
	slpx_lanes_t next_clk_b;
	slpx_lanes_t next_ser_b;
	slpx_lanes_t next_ramp_b;
	logic next_slot_b_undef;
	logic next_sync_crc;
	logic next_sync_fec;

	assign take = REG.req & ~ack;
	assign REG.ack = ack;
	assign REG.rdata = rdata;

	// Writes land whatever link_enable holds; ordering is software's duty
	always_comb begin
		next_link_enable = link_enable;
		next_pd = converter_channel_power_down;
		next_spare_a = spare_lane_enable_link_a;
		next_spare_b = spare_lane_enable_link_b;
		next_sync_header_mode = sync_header_mode_select;
		next_ack = take;
		next_rdata = rdata;
		if (take && REG.we) begin
			unique case (REG.addr)
				`SLPX_OFF_LINK_EN: next_link_enable = REG.wdata[`SLPX_LINK_EN_BIT];
				`SLPX_OFF_PWR_DOWN: next_pd = REG.wdata;
				`SLPX_OFF_SPARE_A: next_spare_a = REG.wdata;
				`SLPX_OFF_SPARE_B: next_spare_b = REG.wdata;
				`SLPX_OFF_SYNC_MODE: next_sync_header_mode = REG.wdata;
				default: next_ack = take;
			endcase
		end
		if (take && !REG.we) begin
			unique case (REG.addr)
				`SLPX_OFF_LINK_EN: next_rdata = {7'h00, link_enable};
				`SLPX_OFF_STATUS: next_rdata = status;
				`SLPX_OFF_PWR_DOWN: next_rdata = converter_channel_power_down;
				`SLPX_OFF_SPARE_A: next_rdata = spare_lane_enable_link_a;
				`SLPX_OFF_SPARE_B: next_rdata = spare_lane_enable_link_b;
				`SLPX_OFF_SYNC_MODE: next_rdata = sync_header_mode_select;
				default: next_rdata = `SLPX_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			link_enable <= 1'b0;
			converter_channel_power_down <= `SLPX_RST_BYTE;
			spare_lane_enable_link_a <= `SLPX_RST_BYTE;
			spare_lane_enable_link_b <= `SLPX_RST_BYTE;
			sync_header_mode_select <= `SLPX_RST_BYTE;
			ack <= 1'b0;
			rdata <= `SLPX_RST_BYTE;
		end else begin
			link_enable <= next_link_enable;
			converter_channel_power_down <= next_pd;
			spare_lane_enable_link_a <= next_spare_a;
			spare_lane_enable_link_b <= next_spare_b;
			sync_header_mode_select <= next_sync_header_mode;
			ack <= next_ack;
			rdata <= next_rdata;
		end
	end

	assign chan_a_power_down = converter_channel_power_down[`SLPX_PD_A_BIT];
	assign chan_b_power_down = converter_channel_power_down[`SLPX_PD_B_BIT];
	assign chan_a_on = ~chan_a_power_down;
	assign chan_b_on = ~chan_b_power_down;
	// Both off also drops serializer PLL and multiframe clock
	assign subsys_on = chan_a_on | chan_b_on;
	// Link A survives a dead B channel when it carries both
	assign link_a_on = subsys_on & chan_a_on;
	assign link_b_on = subsys_on & chan_b_on & ~MODE_BOTH_ON_A_I;
	assign status = {5'h00, link_b_on, link_a_on, subsys_on};

	genvar d;
	generate
		for (d = 0; d < 4; d++) begin : g_dig
			assign dig_on[d] = DIG_CHAN_BIND_I[d] ? chan_b_on : chan_a_on;
		end
	endgenerate

	// Rate and format come from the mode inputs untouched; only gating here
	slpx_lane_gate u_gate_a (
		.link_on_i(link_a_on),
		.mode_lanes_i(MODE_LANES_A_I),
		.spare_i(spare_lane_enable_link_a),
		.test_sel_i(TEST_SEL_I),
		.clk_en_o(clk_a),
		.ser_en_o(ser_a),
		.ramp_o(ramp_a)
	);

	slpx_lane_gate u_gate_b (
		.link_on_i(link_b_on),
		.mode_lanes_i(MODE_LANES_B_I),
		.spare_i(spare_lane_enable_link_b),
		.test_sel_i(TEST_SEL_I),
		.clk_en_o(clk_b),
		.ser_en_o(ser_b),
		.ramp_o(ramp_b)
	);

	assign shm = sync_header_mode_select[`SLPX_SHM_HI:`SLPX_SHM_LO];

	always_comb begin
		next_chan_a_on = chan_a_on;
		next_chan_b_on = chan_b_on;
		next_dig_on = dig_on;
		next_subsys_on = subsys_on;
		next_clk_a = clk_a;
		next_ser_a = ser_a;
		next_ramp_a = ramp_a;
		next_clk_b = clk_b;
		next_ser_b = ser_b;
		next_ramp_b = ramp_b;
		next_slot_b_undef = MODE_BOTH_ON_A_I & link_a_on & chan_b_power_down;
		// Reserved codes send neither header kind
		next_sync_crc = MODE_64B66B_I & (shm == `SLPX_SHM_CRC);
		next_sync_fec = MODE_64B66B_I & (shm == `SLPX_SHM_FEC);
	end

	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			CHAN_A_ON_O <= 1'b0;
			CHAN_B_ON_O <= 1'b0;
			DIG_CHAN_ON_O <= 4'h0;
			SUBSYS_ON_O <= 1'b0;
			LANE_CLK_A_O <= 8'h00;
			LANE_SER_A_O <= 8'h00;
			LANE_RAMP_A_O <= 8'h00;
			LANE_CLK_B_O <= 8'h00;
			LANE_SER_B_O <= 8'h00;
			LANE_RAMP_B_O <= 8'h00;
			SLOT_B_UNDEF_O <= 1'b0;
			SYNC_CRC_O <= 1'b0;
			SYNC_FEC_O <= 1'b0;
		end else begin
			CHAN_A_ON_O <= next_chan_a_on;
			CHAN_B_ON_O <= next_chan_b_on;
			DIG_CHAN_ON_O <= next_dig_on;
			SUBSYS_ON_O <= next_subsys_on;
			LANE_CLK_A_O <= next_clk_a;
			LANE_SER_A_O <= next_ser_a;
			LANE_RAMP_A_O <= next_ramp_a;
			LANE_CLK_B_O <= next_clk_b;
			LANE_SER_B_O <= next_ser_b;
			LANE_RAMP_B_O <= next_ramp_b;
			SLOT_B_UNDEF_O <= next_slot_b_undef;
			SYNC_CRC_O <= next_sync_crc;
			SYNC_FEC_O <= next_sync_fec;
		end
	end

	assign LINK_ENABLE_O = link_enable;
endmodule

// *** design/slpx_host.sv ***
// Controller end: Avalon-MM command registers and safe programming sequence
`timescale 1ns/1ps
module slpx_host (
	input wire logic MCLK_I,
	input wire logic RST_B_I,
	slpx_if.host REG,
	input wire logic [2:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	output logic [1:0] CAL_CONV_OFF_O
);
	import slpx_pkg::*;
	`include "slpx_regs.svh"

	slpx_state_t state;
	slpx_state_t next_state;
	logic av_ack;
	logic next_av_ack;
	logic [31:0] next_readdata;
	logic want_link;
	logic next_want_link;
	slpx_byte_t want_pd;
	slpx_byte_t next_want_pd;
	slpx_byte_t want_a;
	slpx_byte_t next_want_a;
	slpx_byte_t want_b;
	slpx_byte_t next_want_b;
	slpx_byte_t want_sh;
	slpx_byte_t next_want_sh;
	slpx_byte_t dev_status;
	slpx_byte_t next_dev_status;
	logic refused;
	logic next_refused;
	logic [1:0] next_cal;
	logic av_take;
	logic go;
	logic both_pd;
	logic busy;

	assign av_take = (AVS_READ_I | AVS_WRITE_I) & ~av_ack;
	assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~av_ack;
	assign busy = (state != SLPX_IDLE);
	assign go = av_ack & AVS_WRITE_I & (AVS_ADDRESS_I == `SLPX_AV_CTRL)
		& AVS_WRITEDATA_I[`SLPX_CTRL_GO_BIT];
	assign both_pd = want_pd[`SLPX_PD_A_BIT] & want_pd[`SLPX_PD_B_BIT];
	assign REG.req = busy;
	assign REG.we = (state != SLPX_STAT);

	always_comb begin
		REG.addr = `SLPX_OFF_LINK_EN;
		REG.wdata = `SLPX_RST_BYTE;
		unique case (state)
			SLPX_IDLE, SLPX_DIS: REG.wdata = `SLPX_RST_BYTE;
			SLPX_PD: begin
				REG.addr = `SLPX_OFF_PWR_DOWN;
				REG.wdata = want_pd;
			end
			SLPX_XA: begin
				REG.addr = `SLPX_OFF_SPARE_A;
				REG.wdata = want_a;
			end
			SLPX_XB: begin
				REG.addr = `SLPX_OFF_SPARE_B;
				REG.wdata = want_b;
			end
			SLPX_SH: begin
				REG.addr = `SLPX_OFF_SYNC_MODE;
				REG.wdata = want_sh;
			end
			SLPX_EN: REG.wdata = {7'h00, want_link};
			SLPX_STAT: REG.addr = `SLPX_OFF_STATUS;
		endcase
	end

	always_comb begin
		next_state = state;
		next_av_ack = av_take;
		next_readdata = AVS_READDATA_O;
		next_want_link = want_link;
		next_want_pd = want_pd;
		next_want_a = want_a;
		next_want_b = want_b;
		next_want_sh = want_sh;
		next_dev_status = dev_status;
		next_refused = refused;
		next_cal = CAL_CONV_OFF_O;
		if (av_ack && AVS_WRITE_I) begin
			unique case (AVS_ADDRESS_I)
				`SLPX_AV_CTRL: next_want_link = AVS_WRITEDATA_I[`SLPX_CTRL_LINK_BIT];
				`SLPX_AV_PD: next_want_pd = AVS_WRITEDATA_I[7:0];
				`SLPX_AV_SPARE_A: next_want_a = AVS_WRITEDATA_I[7:0];
				`SLPX_AV_SPARE_B: next_want_b = AVS_WRITEDATA_I[7:0];
				`SLPX_AV_SYNC_MODE: next_want_sh = AVS_WRITEDATA_I[7:0];
				default: next_want_link = want_link;
			endcase
		end
		if (av_take && AVS_READ_I) begin
			unique case (AVS_ADDRESS_I)
				`SLPX_AV_CTRL: next_readdata = {30'h0, want_link, 1'b0};
				`SLPX_AV_PD: next_readdata = {24'h0, want_pd};
				`SLPX_AV_SPARE_A: next_readdata = {24'h0, want_a};
				`SLPX_AV_SPARE_B: next_readdata = {24'h0, want_b};
				`SLPX_AV_SYNC_MODE: next_readdata = {24'h0, want_sh};
				`SLPX_AV_STATUS: next_readdata = {16'h0, dev_status, 6'h00, refused, busy};
				default: next_readdata = 32'h0000_0000;
			endcase
		end
		if (busy && REG.ack) begin
			unique case (state)
				SLPX_DIS: next_state = SLPX_PD;
				SLPX_PD: next_state = SLPX_XA;
				SLPX_XA: next_state = SLPX_XB;
				SLPX_XB: next_state = SLPX_SH;
				SLPX_SH: next_state = SLPX_EN;
				SLPX_EN: next_state = SLPX_STAT;
				default: begin
					next_dev_status = REG.rdata;
					next_state = SLPX_IDLE;
				end
			endcase
		end
		// Both off must go through the mode register instead
		if (go && !busy) begin
			next_refused = both_pd;
			next_state = both_pd ? SLPX_IDLE : SLPX_DIS;
			if (!both_pd) begin
				next_cal = (want_pd[`SLPX_PD_A_BIT] ^ want_pd[`SLPX_PD_B_BIT])
					? `SLPX_CAL_OFF_ONE : `SLPX_CAL_OFF_NONE;
			end
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state <= SLPX_IDLE;
			av_ack <= 1'b0;
			AVS_READDATA_O <= 32'h0000_0000;
			want_link <= 1'b0;
			want_pd <= `SLPX_RST_BYTE;
			want_a <= `SLPX_RST_BYTE;
			want_b <= `SLPX_RST_BYTE;
			want_sh <= `SLPX_RST_BYTE;
			dev_status <= `SLPX_RST_BYTE;
			refused <= 1'b0;
			CAL_CONV_OFF_O <= `SLPX_CAL_OFF_NONE;
		end else begin
			state <= next_state;
			av_ack <= next_av_ack;
			AVS_READDATA_O <= next_readdata;
			want_link <= next_want_link;
			want_pd <= next_want_pd;
			want_a <= next_want_a;
			want_b <= next_want_b;
			want_sh <= next_want_sh;
			dev_status <= next_dev_status;
			refused <= next_refused;
			CAL_CONV_OFF_O <= next_cal;
		end
	end
endmodule

// *** sim/slpx_checker.sv ***
// Protocol and ordering checks on the device register port
`timescale 1ns/1ps
`include "slpx_regs.svh"
module slpx_checker (
	input wire logic MCLK_I,
	input wire logic RST_B_I,
	input wire logic req,
	input wire logic we,
	input wire slpx_pkg::slpx_addr_t addr,
	input wire slpx_pkg::slpx_byte_t wdata,
	input wire slpx_pkg::slpx_byte_t rdata,
	input wire logic ack
);
	import slpx_pkg::*;
	logic link_on;
	logic next_link_on;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_B_I);
	// Shadow of the link enable as last written to the device
	always_comb begin
		next_link_on = link_on;
		if (ack && we && addr == `SLPX_OFF_LINK_EN)
			next_link_on = wdata[`SLPX_LINK_EN_BIT];
	end
	always_ff @(posedge MCLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			link_on <= 1'b0;
		else
			link_on <= next_link_on;
	end
	sequence s_taken;
		req && !ack;
	endsequence
	sequence s_answer;
		ack ##1 !ack;
	endsequence
	chk_ack_next_cycle: assert property (s_taken |=> s_answer)
		else $error("request not answered in one cycle");
	chk_ack_has_cause: assert property (ack |-> $past(req) && !$past(ack))
		else $error("answer without request");
	chk_req_held: assert property (s_taken |=> req && $stable(addr) && $stable(we) && $stable(wdata))
		else $error("request changed before answer");
	chk_idle_no_ack: assert property (!req [*2] |-> !ack)
		else $error("answer while idle");
	chk_rdata_stands: assert property (!(req && !ack && !we) |=> $stable(rdata))
		else $error("read data changed without a read");
	chk_pd_link_off: assert property (req && we && addr == `SLPX_OFF_PWR_DOWN |-> !link_on)
		else $error("power-down written with link enabled");
	chk_spare_link_off: assert property (
		req && we && (addr == `SLPX_OFF_SPARE_A || addr == `SLPX_OFF_SPARE_B) |-> !link_on)
		else $error("spare lanes written with link enabled");
	chk_cfg_after_off: assert property (
		s_taken && we && addr == `SLPX_OFF_PWR_DOWN |-> $past(ack) && $past(we)
		&& $past(addr) == `SLPX_OFF_LINK_EN && !$past(wdata[`SLPX_LINK_EN_BIT]))
		else $error("power-down write not preceded by link disable");
endmodule

// *** sim/test_serial_lane_power_and_extra_lane_ctrl.sv ***
// Self-checking bench for both ends of the spare-lane power control
`timescale 1ns/1ps
module test_serial_lane_power_and_extra_lane_ctrl;
	import slpx_pkg::*;
	logic mclk, rst_b, both_a, m64, chan_a, chan_b, subsys, link_en, slot_b, crc, fec;
	logic av_rd, av_wr, av_wait;
	logic [1:0] cal, cur_pd;
	logic [2:0] tsel, av_addr;
	logic [3:0] bind_sel, dig;
	logic [31:0] av_wd, av_rdata, r1, r2;
	slpx_lanes_t lanes_a, lanes_b, clk_a, ser_a, ramp_a, clk_b, ser_b, ramp_b;
	int n_mismatch, cmp_count, cycles;
	slpx_if reg_if();
	slpx_device u_slpx_device (.MCLK_I(mclk), .RST_B_I(rst_b), .REG(reg_if.dev),
		.MODE_LANES_A_I(lanes_a), .MODE_LANES_B_I(lanes_b), .MODE_BOTH_ON_A_I(both_a),
		.MODE_64B66B_I(m64), .TEST_SEL_I(tsel), .DIG_CHAN_BIND_I(bind_sel), .CHAN_A_ON_O(chan_a),
		.CHAN_B_ON_O(chan_b), .DIG_CHAN_ON_O(dig), .SUBSYS_ON_O(subsys), .LINK_ENABLE_O(link_en),
		.LANE_CLK_A_O(clk_a), .LANE_SER_A_O(ser_a), .LANE_RAMP_A_O(ramp_a), .LANE_CLK_B_O(clk_b),
		.LANE_SER_B_O(ser_b), .LANE_RAMP_B_O(ramp_b), .SLOT_B_UNDEF_O(slot_b),
		.SYNC_CRC_O(crc), .SYNC_FEC_O(fec));
	slpx_host u_slpx_host (.MCLK_I(mclk), .RST_B_I(rst_b), .REG(reg_if.host),
		.AVS_ADDRESS_I(av_addr), .AVS_READ_I(av_rd), .AVS_WRITE_I(av_wr),
		.AVS_WRITEDATA_I(av_wd), .AVS_READDATA_O(av_rdata), .AVS_WAITREQUEST_O(av_wait),
		.CAL_CONV_OFF_O(cal));
	slpx_checker u_slpx_checker (.MCLK_I(mclk), .RST_B_I(rst_b), .req(reg_if.req),
		.we(reg_if.we), .addr(reg_if.addr), .wdata(reg_if.wdata), .rdata(reg_if.rdata),
		.ack(reg_if.ack));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("Counts: compares=%0d mismatches=%0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Request held until waitrequest is seen low at a rising edge
	task automatic av_go(input logic [2:0] a, input logic wr, input logic [31:0] d);
		@(posedge mclk);
		av_addr <= a;
		av_rd <= !wr;
		av_wr <= wr;
		av_wd <= d;
		do
			@(posedge mclk);
		while (av_wait !== 1'b0);
		av_rd <= 1'b0;
		av_wr <= 1'b0;
	endtask
	// Expected {ramp, serializer, clock} per link
	function automatic logic [23:0] f_link(input slpx_lanes_t mode, input slpx_lanes_t sp,
		input logic on, input logic [2:0] t);
		slpx_lanes_t en;
		slpx_lanes_t ser;
		slpx_lanes_t ramp;
		logic low;
		en = on ? (mode | {sp[7:1], 1'b0}) : 8'h00;
		ramp = (t == 3'h0 || t == 3'h5) ? (en & ~mode) : 8'h00;
		low = 1'b1;
		for (int n = 0; n < 8; n++) begin
			ser[n] = (mode[n] | (sp[n] & sp[0] & (n != 0))) & on & low;
			low = low & en[n];
		end
		return {ramp, ser, en};
	endfunction
	task automatic run_case(input logic [31:0] a, input logic [31:0] b, input logic want);
		logic ca;
		logic cb;
		int k;
		@(posedge mclk);
		lanes_a <= b[7:0];
		lanes_b <= b[15:8];
		both_a <= b[16];
		m64 <= b[17];
		tsel <= b[20:18];
		bind_sel <= b[24:21];
		for (int i = 1; i < 5; i++)
			av_go(i[2:0], 1'b1, {24'h0, a[8 * i - 8 +: 8]});
		av_go(3'h0, 1'b1, {30'h0, want, 1'b1});
		k = 0;
		do begin
			av_go(3'h5, 1'b0, 32'h0);
			k++;
		end while (av_rdata[0] !== 1'b0 && k < 40);
		check(av_rdata[0], 1'b0);
		check(av_rdata[1], a[1:0] == 2'h3);
		if (a[1:0] != 2'h3)
			cur_pd = a[1:0];
		ca = !cur_pd[0];
		cb = !cur_pd[1];
		check({chan_a, chan_b, subsys}, {ca, cb, ca | cb});
		if (a[1:0] != 2'h3) begin
			if (want)
				check(av_rdata[15:8], {5'h0, cb & !b[16], ca, ca | cb});
			for (int i = 0; i < 4; i++)
				check(dig[i], b[21 + i] ? cb : ca);
			check(slot_b, b[16] & !cb);
			check({ramp_a, ser_a, clk_a}, f_link(b[7:0], a[15:8], ca, b[20:18]));
			check({ramp_b, ser_b, clk_b}, f_link(b[15:8], a[23:16], cb & !b[16], b[20:18]));
			check({crc, fec}, {b[17] && a[25:24] == 2'h0, b[17] && a[25:24] == 2'h2});
			check(link_en, want);
			check(cal, (ca ^ cb) ? 2'h1 : 2'h0);
			av_go(3'h4, 1'b0, 32'h0);
			check(av_rdata, {24'h0, a[31:24]});
		end
		$display("Case done pd=%h spare=%h/%h", a[7:0], a[15:8], a[23:16]);
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Hang guard well above the expected run length
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_mismatch++;
			final_report();
		end
	end
	initial begin
		{rst_b, both_a, m64, av_rd, av_wr, tsel, av_addr, bind_sel} = '0;
		{lanes_a, lanes_b, av_wd, cur_pd} = '0;
		{n_mismatch, cmp_count, cycles} = '0;
		void'($urandom(32'h3ce8ec31));
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		@(negedge mclk);
		check({chan_a, chan_b, subsys, link_en, clk_a, clk_b}, 20'hE0000);
		for (int i = 1; i < 5; i++) begin
			av_go(i[2:0], 1'b0, 32'h0);
			check(av_rdata, 32'h0);
		end
		// Unmapped word must not disturb the map
		av_go(3'h7, 1'b1, 32'hFF);
		av_go(3'h1, 1'b0, 32'h0);
		check(av_rdata, 32'h0);
		$display("Reset test done");
		run_case(32'h00FEFF00, 32'h00020101, 1'b1);
		run_case(32'hFE00B5FD, 32'h00160003, 1'b1);
		run_case(32'h0203FF03, 32'h00000000, 1'b1);
		run_case(32'h01FFFF02, 32'h00030F01, 1'b0);
		for (int i = 0; i < 24; i++) begin
			r1 = $urandom;
			r2 = $urandom;
			run_case(r1, r2, r2[31]);
		end
		final_report();
	end
endmodule
